// file: src/fpre_defines.svh
/*
  Offsets, field positions, reset values and timing counts of the
  rounding and exception unit. Assumes single-precision operands only.
*/
`ifndef FPRE_DEFINES_SVH
`define FPRE_DEFINES_SVH

// register byte offsets on the AXI4-Lite slave
`define FPRE_CTL_OFS 4'h0
`define FPRE_OPSTAT_OFS 4'h4

// fp_status_control field positions
`define FPRE_BANK_BIT 21
`define FPRE_PAIR_BIT 20
`define FPRE_PREC_BIT 19
`define FPRE_FLUSH_BIT 18
`define FPRE_CAUSE_HI 17
`define FPRE_CAUSE_LO 12
`define FPRE_EN_HI 11
`define FPRE_EN_LO 7
`define FPRE_FLAG_HI 6
`define FPRE_FLAG_LO 2
`define FPRE_RMODE_HI 1
`define FPRE_RMODE_LO 0

// reset value (flush on, round toward zero) and writable bits
`define FPRE_CTL_RST 32'h0004_0001
`define FPRE_CTL_MASK 32'h003F_FFFF

// load of the status/control word occupies this many cycles
`define FPRE_LOAD_CYCLES 4

// single-precision encodings
`define FPRE_QNAN 32'h7FC0_0000
`define FPRE_EXP_MAX 10'h0FF
`define FPRE_BIG_MAG 31'h7F7F_FFFF
`define FPRE_INF_MAG 31'h7F80_0000

// AXI responses
`define FPRE_RESP_OKAY 2'h0
`define FPRE_RESP_SLVERR 2'h2

`endif

// file: src/fpre_pkg.sv
/*
  Types of the rounding and exception unit: operation codes, control
  states, the rounding answer and the whole register state.
  Uses no define; every numeric constant here is written out as a literal.
*/
package fpre_pkg;

  typedef enum logic [3:0] {
    FPRE_OP_NOP = 4'h0,
    FPRE_OP_FLOAT_ADD = 4'h1,
    FPRE_OP_FLOAT_SUBTRACT = 4'h2,
    FPRE_OP_FLOAT_MULTIPLY = 4'h3,
    FPRE_OP_FUSED_MAC = 4'h4,
    FPRE_OP_DIVIDE = 4'h5,
    FPRE_OP_RECIP_SQRT = 4'h6,
    FPRE_OP_INNER_PRODUCT = 4'h7,
    FPRE_OP_MATRIX_XFORM = 4'h8,
    FPRE_OP_FLOAT_MOVE = 4'h9,
    FPRE_OP_BANK_SWAP = 4'hA,
    FPRE_OP_SIZE_TOGGLE = 4'hB,
    FPRE_OP_LOAD_SYSREG = 4'hC
  } fpre_op_e;

  typedef enum logic [1:0] {
    FPRE_ST_IDLE = 2'h1,
    FPRE_ST_LOAD = 2'h2
  } fpre_state_e;

  typedef struct packed {
    logic [31:0] value;
    logic ovf;
    logic unf;
    logic inx;
  } fpre_rnd_s;

  typedef struct packed {
    logic [31:0] ctl;
    fpre_state_e state;
    logic [3:0] cnt;
    logic [31:0] load_data;
    logic op_ready;
    logic res_valid;
    logic [31:0] res_data;
    logic res_pair;
    logic trap;
    logic dis_gen;
    logic dis_slot;
    logic last_trap;
    logic last_dis;
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fpre_state_s;

endpackage

// file: src/fpre_unit.sv
/*
  Rounding and exception unit of the floating-point pipe: rounds one
  unrounded single-precision value per operation, raises cause/flag
  bits, decides between trap and default result, and handles the
  bank-swap, size-toggle, pair-move and status-load operations.
  Assumes the integer pipeline presents one operation at a time with
  a normalised 24-bit significand, a round bit and a sticky bit, and
  takes the trap and disable pulses as exception requests.
*/
// The register addresses and register access over AXI4-Lite are this design's own decisions.
// What this block does
// - rounding field code 00 picks round nearest, 01 round toward zero
// - fused multiply-accumulate rounds once, on its final unrounded value
// - nearest mode returns closest normal value, ties go to even significand; denormal results truncate
// - nearest mode: magnitude at or above overflow threshold gives signed infinity
// - toward-zero mode truncates the round bit and every digit below it
// - toward-zero mode saturates oversize magnitudes to signed largest value
// - operation with unit disabled raises slot or general disable exception
// - six sources: error, invalid, divide by zero, overflow, underflow, inexact
// - inexact reported on overflow, underflow or any rounding
// - cause holds six bits, enable and flag five; error always traps
// - occurring source sets cause and flag (error sets cause only); absent source clears cause only
// - invalid enabled traps invalid or matrix op; zero-divide enabled traps zero divisor
// - overflow, underflow, inexact enabled trap any operation that might raise them
// - all traps share one event; destination stays unwritten on trap
// - untrapped source writes default: quiet NaN, signed infinity, inexact result
// - untrapped overflow: largest normal toward zero, infinity at nearest
// - untrapped underflow: denormal or zero without flush, signed zero with flush
// - inner product and matrix transform always set inexact cause and flag
// - geometric ops may drop small partial products within the error bound
// - bank swap toggles bank select in one cycle; status load takes four cycles
// - with transfer size set, moves carry register pairs of two words
// - size toggle inverts the transfer size bit
// - cause at 17..12, enable at 11..7, flag at 6..2, all reset zero
`timescale 1ns/10ps
`default_nettype none
`include "fpre_defines.svh"

module fpre_unit import fpre_pkg::*; #(
  parameter int LOAD_CYCLES = `FPRE_LOAD_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic OP_VALID,
  output logic OP_READY,
  input wire logic [3:0] OP_CODE,
  input wire logic OP_SIGN,
  input wire logic [9:0] OP_EXP,
  input wire logic [23:0] OP_MANT,
  input wire logic OP_ROUND,
  input wire logic OP_STICKY,
  input wire logic OP_DENORM_IN,
  input wire logic OP_INVALID,
  input wire logic OP_ZERO_DIV,
  input wire logic OP_DELAY_SLOT,
  input wire logic [31:0] OP_DATA,
  input wire logic FPU_DISABLE,
  output logic RES_VALID,
  output logic [31:0] RES_DATA,
  output logic RES_PAIR,
  output logic FPU_TRAP,
  output logic DISABLE_GENERAL,
  output logic DISABLE_SLOT
);

  // the load counter is four bits wide and needs at least two cycles
  if (LOAD_CYCLES < 2 || LOAD_CYCLES > 15) begin : g_bad_load
    $error("LOAD_CYCLES must lie between 2 and 15");
  end

  localparam logic [3:0] LOAD_LAST = 4'(LOAD_CYCLES - 1);

  // one rounding step; fused multiply-accumulate arrives unrounded, so it is rounded only here
  function automatic fpre_rnd_s fpre_round(input logic s, input logic signed [9:0] e, input logic [23:0] m,
                                           input logic rb, input logic sb, input logic rz, input logic dn);
    fpre_rnd_s r;
    logic inc;
    logic [24:0] sum;
    logic [9:0] ef;
    logic [23:0] mf;
    logic [9:0] sh;
    logic [23:0] den;
    r = '0;
    r.inx = rb | sb;
    inc = !rz & rb & (sb | m[0]);
    sum = {1'h0, m} + {24'h000000, inc};
    ef = e + {9'h000, sum[24]};
    mf = sum[24] ? sum[24:1] : sum[23:0];
    sh = 10'h001 - e;
    den = (sh > 10'h017) ? 24'h000000 : (m >> sh);
    if (e <= $signed(10'h000)) begin
      // denormal path truncates; a tie here is not rounded up
      r.unf = 1'h1;
      r.inx = 1'h1;
      r.value = {s, 8'h00, dn ? 23'h000000 : den[22:0]};
    end else if ($signed(ef) >= $signed(`FPRE_EXP_MAX)) begin
      r.ovf = 1'h1;
      r.inx = 1'h1;
      r.value = {s, rz ? `FPRE_BIG_MAG : `FPRE_INF_MAG};
    end else begin
      r.value = {s, ef[7:0], mf[22:0]};
    end
    return r;
  endfunction

  // kinds: 0 overflow, 1 underflow, 2 inexact
  function automatic logic fpre_may(input logic [3:0] op, input int kind);
    logic arith;
    arith = (op >= FPRE_OP_FLOAT_ADD) && (op <= FPRE_OP_MATRIX_XFORM) && (op != FPRE_OP_RECIP_SQRT);
    return arith || (kind == 2 && op == FPRE_OP_RECIP_SQRT);
  endfunction

  fpre_state_s st;
  fpre_state_s nx;
  fpre_rnd_s rnd;
  logic op_fire;
  logic wr_fire;
  logic arith;
  logic geom;
  logic [5:0] src;
  logic [4:0] en;
  logic take_trap;
  logic [31:0] wmask;

  // one next-state process for bus, operation and load sequencing
  always_comb begin
    nx = st;
    rnd = '0;
    op_fire = OP_VALID && st.op_ready;
    wr_fire = 1'h0;
    arith = 1'h0;
    geom = 1'h0;
    src = 6'h00;
    en = st.ctl[`FPRE_EN_HI:`FPRE_EN_LO];
    take_trap = 1'h0;
    wmask = {{8{st.wstrb[3]}}, {8{st.wstrb[2]}}, {8{st.wstrb[1]}}, {8{st.wstrb[0]}}} & `FPRE_CTL_MASK;
    nx.res_valid = 1'h0;
    nx.res_pair = 1'h0;
    nx.trap = 1'h0;
    nx.dis_gen = 1'h0;
    nx.dis_slot = 1'h0;

    // write address and data are taken independently, answered once both are held
    if (S_AXI_AWVALID && st.awready) begin
      nx.aw_held = 1'h1;
      nx.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && st.wready) begin
      nx.w_held = 1'h1;
      nx.wdata = S_AXI_WDATA;
      nx.wstrb = S_AXI_WSTRB;
    end
    if (S_AXI_BREADY && st.bvalid) begin
      nx.bvalid = 1'h0;
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      nx.aw_held = 1'h0;
      nx.w_held = 1'h0;
      nx.bvalid = 1'h1;
      nx.bresp = `FPRE_RESP_OKAY;
      if (st.awaddr[3:2] == 2'(`FPRE_CTL_OFS >> 2)) begin
        wr_fire = 1'h1;
        nx.ctl = (st.ctl & ~wmask) | (st.wdata & wmask);
      end else if (st.awaddr[3:2] != 2'(`FPRE_OPSTAT_OFS >> 2)) begin
        nx.bresp = `FPRE_RESP_SLVERR;
      end
    end
    nx.awready = !nx.aw_held && !nx.bvalid;
    nx.wready = !nx.w_held && !nx.bvalid;

    // read channel: one word, unmapped answers zero with an error
    if (S_AXI_RREADY && st.rvalid) begin
      nx.rvalid = 1'h0;
    end
    if (S_AXI_ARVALID && st.arready) begin
      nx.rvalid = 1'h1;
      nx.rresp = `FPRE_RESP_OKAY;
      case (S_AXI_ARADDR[3:2])
        2'(`FPRE_CTL_OFS >> 2): nx.rdata = st.ctl;
        2'(`FPRE_OPSTAT_OFS >> 2): nx.rdata = {29'h00000000, !st.op_ready, st.last_trap, st.last_dis};
        default: begin
          nx.rdata = 32'h00000000;
          nx.rresp = `FPRE_RESP_SLVERR;
        end
      endcase
    end
    nx.arready = !nx.rvalid;

    // operation sequencing; op effects land after a same-cycle bus write so hardware sets win
    case (st.state)
      FPRE_ST_IDLE: begin
        if (op_fire && FPU_DISABLE) begin
          nx.dis_slot = OP_DELAY_SLOT;
          nx.dis_gen = !OP_DELAY_SLOT;
          nx.last_dis = 1'h1;
        end else if (op_fire) begin
          nx.last_dis = 1'h0;
          case (OP_CODE)
            FPRE_OP_BANK_SWAP: nx.ctl[`FPRE_BANK_BIT] = !nx.ctl[`FPRE_BANK_BIT];
            FPRE_OP_SIZE_TOGGLE: nx.ctl[`FPRE_PAIR_BIT] = !nx.ctl[`FPRE_PAIR_BIT];
            FPRE_OP_FLOAT_MOVE: begin
              nx.res_valid = 1'h1;
              nx.res_data = OP_DATA;
              nx.res_pair = st.ctl[`FPRE_PAIR_BIT];
            end
            FPRE_OP_LOAD_SYSREG: begin
              nx.state = FPRE_ST_LOAD;
              nx.cnt = LOAD_LAST;
              nx.load_data = OP_DATA;
              nx.op_ready = 1'h0;
            end
            default: begin
              arith = (OP_CODE >= FPRE_OP_FLOAT_ADD) && (OP_CODE <= FPRE_OP_MATRIX_XFORM);
              geom = (OP_CODE == FPRE_OP_INNER_PRODUCT) || (OP_CODE == FPRE_OP_MATRIX_XFORM);
            end
          endcase
        end
      end
      FPRE_ST_LOAD: begin
        // status word is held back while the unit state settles
        nx.cnt = st.cnt - 4'h1;
        if (st.cnt == 4'h1) begin
          nx.ctl = st.load_data & `FPRE_CTL_MASK;
          nx.state = FPRE_ST_IDLE;
          nx.op_ready = 1'h1;
        end
      end
      default: begin
        nx.state = FPRE_ST_IDLE;
        nx.op_ready = 1'h1;
      end
    endcase

    // exception sources, trap decision and default results
    if (arith) begin
      // codes 10 and 11 are reserved; only bit 0 is looked at
      rnd = fpre_round(OP_SIGN, $signed(OP_EXP), OP_MANT, OP_ROUND, OP_STICKY, st.ctl[`FPRE_RMODE_LO],
                       st.ctl[`FPRE_FLUSH_BIT]);
      src[5] = OP_DENORM_IN && !st.ctl[`FPRE_FLUSH_BIT];
      src[4] = OP_INVALID && !src[5];
      src[3] = OP_ZERO_DIV && !src[5] && !src[4] &&
               (OP_CODE == FPRE_OP_DIVIDE || OP_CODE == FPRE_OP_RECIP_SQRT);
      src[2] = rnd.ovf && (src[5:3] == 3'h0);
      src[1] = rnd.unf && (src[5:3] == 3'h0);
      // geometric ops drop small partial products, so inexact is simply assumed
      src[0] = (rnd.inx && (src[5:3] == 3'h0)) || geom;
      take_trap = src[5] || (en[4] && (src[4] || OP_CODE == FPRE_OP_MATRIX_XFORM)) ||
                  (en[3] && src[3]) || (en[2] && fpre_may(OP_CODE, 0)) ||
                  (en[1] && fpre_may(OP_CODE, 1)) || (en[0] && fpre_may(OP_CODE, 2));
      nx.ctl[`FPRE_CAUSE_HI:`FPRE_CAUSE_LO] = src;
      nx.ctl[`FPRE_FLAG_HI:`FPRE_FLAG_LO] = nx.ctl[`FPRE_FLAG_HI:`FPRE_FLAG_LO] | src[4:0];
      nx.last_trap = take_trap;
      nx.trap = take_trap;
      nx.res_valid = !take_trap;
      if (src[4]) begin
        nx.res_data = `FPRE_QNAN;
      end else if (src[3]) begin
        nx.res_data = {OP_SIGN, `FPRE_INF_MAG};
      end else begin
        nx.res_data = rnd.value;
      end
    end
  end

  // the whole state registers here; reset takes constants only
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st <= '0;
      st.ctl <= `FPRE_CTL_RST;
      st.state <= FPRE_ST_IDLE;
      st.op_ready <= 1'h1;
      st.awready <= 1'h1;
      st.wready <= 1'h1;
      st.arready <= 1'h1;
    end else begin
      st <= nx;
    end
  end

  // every output is a register field
  assign S_AXI_AWREADY = st.awready;
  assign S_AXI_WREADY = st.wready;
  assign S_AXI_BRESP = st.bresp;
  assign S_AXI_BVALID = st.bvalid;
  assign S_AXI_ARREADY = st.arready;
  assign S_AXI_RDATA = st.rdata;
  assign S_AXI_RRESP = st.rresp;
  assign S_AXI_RVALID = st.rvalid;
  assign OP_READY = st.op_ready;
  assign RES_VALID = st.res_valid;
  assign RES_DATA = st.res_data;
  assign RES_PAIR = st.res_pair;
  assign FPU_TRAP = st.trap;
  assign DISABLE_GENERAL = st.dis_gen;
  assign DISABLE_SLOT = st.dis_slot;

  // helper: a clean add with all traps masked, so the result is always written
  logic add_clean;
  assign add_clean = op_fire && !FPU_DISABLE && OP_CODE == FPRE_OP_FLOAT_ADD && !OP_DENORM_IN &&
                     !OP_INVALID && st.ctl[`FPRE_EN_HI:`FPRE_EN_LO] == 5'h00;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  property p_disable_kind;
    op_fire && FPU_DISABLE |=> (DISABLE_SLOT == $past(OP_DELAY_SLOT)) && (DISABLE_GENERAL != DISABLE_SLOT)
                              && !RES_VALID && !FPU_TRAP;
  endproperty
  a_disable_kind: assert property (p_disable_kind) else $error("disable exception kind wrong");

  property p_trap_no_write;
    FPU_TRAP |-> !RES_VALID;
  endproperty
  a_trap_no_write: assert property (p_trap_no_write) else $error("result written on trap");

  property p_error_traps;
    op_fire && !FPU_DISABLE && OP_CODE == FPRE_OP_FLOAT_ADD && OP_DENORM_IN && !st.ctl[`FPRE_FLUSH_BIT]
      |=> FPU_TRAP && st.ctl[`FPRE_CAUSE_HI];
  endproperty
  a_error_traps: assert property (p_error_traps) else $error("fpu error did not trap");

  property p_geom_inexact;
    op_fire && !FPU_DISABLE && (OP_CODE == FPRE_OP_INNER_PRODUCT || OP_CODE == FPRE_OP_MATRIX_XFORM)
      |=> st.ctl[`FPRE_CAUSE_LO] && st.ctl[`FPRE_FLAG_LO];
  endproperty
  a_geom_inexact: assert property (p_geom_inexact) else $error("geometric op left inexact clear");

  property p_flag_sticky;
    !wr_fire && st.state != FPRE_ST_LOAD |=> (st.ctl[6:2] & $past(st.ctl[6:2])) == $past(st.ctl[6:2]);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag bit fell without software");

  property p_bank_swap;
    op_fire && !FPU_DISABLE && OP_CODE == FPRE_OP_BANK_SWAP && !wr_fire
      |=> st.ctl[`FPRE_BANK_BIT] != $past(st.ctl[`FPRE_BANK_BIT]);
  endproperty
  a_bank_swap: assert property (p_bank_swap) else $error("bank select not toggled");

  property p_size_toggle;
    op_fire && !FPU_DISABLE && OP_CODE == FPRE_OP_SIZE_TOGGLE && !wr_fire
      |=> st.ctl[`FPRE_PAIR_BIT] != $past(st.ctl[`FPRE_PAIR_BIT]);
  endproperty
  a_size_toggle: assert property (p_size_toggle) else $error("transfer size not toggled");

  property p_load_len;
    op_fire && !FPU_DISABLE && OP_CODE == FPRE_OP_LOAD_SYSREG |=> !OP_READY [*3] ##1 OP_READY;
  endproperty
  a_load_len: assert property (p_load_len) else $error("status load length wrong");

  property p_rn_overflow;
    add_clean && st.ctl[1:0] == 2'h0 && $signed(OP_EXP) >= $signed(10'h0FF)
      |=> RES_VALID && RES_DATA[30:0] == `FPRE_INF_MAG && RES_DATA[31] == $past(OP_SIGN);
  endproperty
  a_rn_overflow: assert property (p_rn_overflow) else $error("nearest overflow not infinity");

  property p_rz_saturate;
    add_clean && st.ctl[1:0] == 2'h1 && $signed(OP_EXP) >= $signed(10'h0FF)
      |=> RES_VALID && RES_DATA[30:0] == `FPRE_BIG_MAG && st.ctl[14] && st.ctl[12];
  endproperty
  a_rz_saturate: assert property (p_rz_saturate) else $error("toward-zero overflow not saturated");

  property p_rz_truncate;
    add_clean && st.ctl[1:0] == 2'h1 && $signed(OP_EXP) >= $signed(10'h001) && $signed(OP_EXP) <= $signed(10'h0C8)
      |=> RES_DATA[22:0] == $past(OP_MANT[22:0]) && RES_DATA[30:23] == $past(OP_EXP[7:0]);
  endproperty
  a_rz_truncate: assert property (p_rz_truncate) else $error("toward-zero did not truncate");

  property p_tie_even;
    add_clean && st.ctl[1:0] == 2'h0 && $signed(OP_EXP) >= $signed(10'h001) && $signed(OP_EXP) <= $signed(10'h0C8)
      && OP_ROUND && !OP_STICKY && !OP_MANT[0] |=> RES_DATA[22:0] == $past(OP_MANT[22:0]);
  endproperty
  a_tie_even: assert property (p_tie_even) else $error("tie not rounded to even");

  c_load: cover property (op_fire && OP_CODE == FPRE_OP_LOAD_SYSREG ##4 OP_READY);
  c_trap: cover property (FPU_TRAP);
  c_slot: cover property (DISABLE_SLOT);
  c_pair: cover property (RES_PAIR);

endmodule
`default_nettype wire

// file: dv/fpre_cpu_model.sv
/*
  Model of the integer pipeline that issues floating-point operations
  and notes the answer it expects for each one that is not muted.
  Assumes the bench calls op and idle just after a rising clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module fpre_cpu_model (
  input wire logic REF_CLK,
  input wire logic OP_READY,
  output logic OP_VALID,
  output logic [3:0] OP_CODE,
  output logic OP_SIGN,
  output logic [9:0] OP_EXP,
  output logic [23:0] OP_MANT,
  output logic OP_ROUND,
  output logic OP_STICKY,
  output logic OP_DENORM_IN,
  output logic OP_INVALID,
  output logic OP_ZERO_DIV,
  output logic OP_DELAY_SLOT,
  output logic [31:0] OP_DATA,
  output logic FPU_DISABLE
);
  logic [35:0] q[$];
  logic mute;
  // quiet request lines at time zero
  initial begin
    {OP_VALID, OP_CODE, OP_SIGN, OP_EXP, OP_MANT, OP_ROUND, OP_STICKY} = '0;
    {OP_DENORM_IN, OP_INVALID, OP_ZERO_DIV, OP_DELAY_SLOT, OP_DATA, FPU_DISABLE, mute} = '0;
  end
  task automatic idle();
    OP_VALID <= 1'b0;
  endtask
  // gap makes slow issue; request held until taken, since busy refuses it
  task automatic op(input int gap, input logic [3:0] c, input logic s, input logic [9:0] e, input logic [23:0] m,
                    input logic [1:0] rs, input logic [4:0] fl, input logic [31:0] d, input logic [35:0] x,
                    input logic mt);
    if (gap > 0) begin
      OP_VALID <= 1'b0;
      repeat (gap) @(posedge REF_CLK);
    end
    if (!mt) q.push_back(x);
    OP_VALID <= 1'b1;
    {OP_CODE, OP_SIGN, OP_EXP, OP_MANT, OP_ROUND, OP_STICKY, OP_DATA} <= {c, s, e, m, rs, d};
    {FPU_DISABLE, OP_DELAY_SLOT, OP_ZERO_DIV, OP_INVALID, OP_DENORM_IN} <= fl;
    do @(posedge REF_CLK); while (!OP_READY);
    mute <= mt; // register ops leave no answer
  endtask
endmodule
`default_nettype wire

// file: dv/test_fpre_unit.sv
/*
  Bench of the rounding and exception unit: AXI4-Lite master tasks,
  the pipeline model and one monitor comparing answers to queued notes.
  Assumes an operation answers in the cycle after it is taken.
*/
`timescale 1ns/10ps
`default_nettype none
module test_fpre_unit;
  localparam int LOAD_CYC = 4;
  logic REF_CLK = 1'b0, ARST_N = 1'b0;
  logic [3:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0, S_AXI_WSTRB = 4'hF, OP_CODE;
  logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA, OP_DATA, RES_DATA, d;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_BREADY = 1'b1, S_AXI_RREADY = 1'b1;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, OP_VALID, OP_READY, OP_SIGN;
  logic OP_ROUND, OP_STICKY, OP_DENORM_IN, OP_INVALID, OP_ZERO_DIV, OP_DELAY_SLOT, FPU_DISABLE;
  logic RES_VALID, RES_PAIR, FPU_TRAP, DISABLE_GENERAL, DISABLE_SLOT;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [9:0] OP_EXP;
  logic [23:0] OP_MANT;
  logic [35:0] rq[$];
  int err_count = 0, total_checks = 0, cyc = 0, seed = 77740, n;

  fpre_unit #(.LOAD_CYCLES(LOAD_CYC)) u_fpre_unit (.REF_CLK, .ARST_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY,
    .OP_VALID, .OP_READY, .OP_CODE, .OP_SIGN, .OP_EXP, .OP_MANT, .OP_ROUND, .OP_STICKY, .OP_DENORM_IN,
    .OP_INVALID, .OP_ZERO_DIV, .OP_DELAY_SLOT, .OP_DATA, .FPU_DISABLE, .RES_VALID, .RES_DATA, .RES_PAIR,
    .FPU_TRAP, .DISABLE_GENERAL, .DISABLE_SLOT);
  fpre_cpu_model u_fpre_cpu_model (.REF_CLK, .OP_READY, .OP_VALID, .OP_CODE, .OP_SIGN, .OP_EXP, .OP_MANT,
    .OP_ROUND, .OP_STICKY, .OP_DENORM_IN, .OP_INVALID, .OP_ZERO_DIV, .OP_DELAY_SLOT, .OP_DATA, .FPU_DISABLE);

  always #50 REF_CLK = ~REF_CLK;

  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // random gap of 0..2 cycles mixes back-to-back and slow issue
  task automatic op(input logic [3:0] c, input logic s, input logic [9:0] e, input logic [23:0] m,
                    input logic [1:0] rs, input logic [4:0] fl, input logic [35:0] x, input logic [31:0] dd = 32'h0,
                    input logic mt = 1'b0);
    u_fpre_cpu_model.op(int'($unsigned($random(seed)) % 3), c, s, e, m, rs, fl, dd, x, mt);
  endtask
  // exact operand of one, used wherever rounding is not the point
  task automatic one(input logic [3:0] c, input logic [4:0] fl, input logic [35:0] x,
                     input logic [31:0] dd = 32'h0, input logic mt = 1'b0);
    op(c, 1'b0, 10'd127, 24'h800000, 2'b00, fl, x, dd, mt);
  endtask
  // each channel released at its own handshake; idle edge lets ops settle
  task automatic wr(input logic [3:0] a, input logic [31:0] dd, input logic [1:0] e);
    u_fpre_cpu_model.idle();
    @(posedge REF_CLK);
    rq.push_back({2'h0, e, 32'h0});
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= dd;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    do begin
      @(posedge REF_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (!S_AXI_BVALID);
  endtask
  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    u_fpre_cpu_model.idle();
    @(posedge REF_CLK);
    rq.push_back({2'h0, e});
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    do begin
      @(posedge REF_CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!S_AXI_RVALID);
  endtask

  // monitor: oldest note against each answer; register ops are muted
  always @(posedge REF_CLK) begin
    if (!u_fpre_cpu_model.mute && (RES_VALID | FPU_TRAP | DISABLE_GENERAL | DISABLE_SLOT))
      check({RES_PAIR, DISABLE_SLOT, DISABLE_GENERAL, FPU_TRAP, RES_VALID ? RES_DATA : 32'h0},
            u_fpre_cpu_model.q.size() ? u_fpre_cpu_model.q.pop_front() : 36'hF_FFFF_FFFF);
    // address readies must stay low while an answer stands
    if (S_AXI_BVALID && S_AXI_BREADY)
      check({S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BRESP, 32'h0}, rq.pop_front());
    if (S_AXI_RVALID && S_AXI_RREADY)
      check({1'b0, S_AXI_ARREADY, S_AXI_RRESP, S_AXI_RDATA}, rq.pop_front());
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    repeat (6) @(posedge REF_CLK);
    ARST_N <= 1'b1;
    rd(4'h0, 34'h0_0004_0001);
    rd(4'h8, 34'h2_0000_0000);
    wr(4'hC, 32'hFFFF_FFFF, 2'h2);
    wr(4'h4, 32'h0000_0007, 2'h0);
    rd(4'h4, 34'h0);
    // toward zero: truncation, saturation
    op(1, 0, 10'd128, 24'hC00001, 2'b11, 5'h0, 36'h0_4040_0001);
    rd(4'h0, 34'h0_0004_1005);
    op(1, 1, 10'd255, 24'h800000, 2'b00, 5'h0, 36'h0_FF7F_FFFF);
    wr(4'h0, 32'h0004_0000, 2'h0);
    // nearest: ties to even, carry out, overflow boundary
    op(1, 0, 10'd128, 24'h800001, 2'b10, 5'h0, 36'h0_4000_0002);
    op(1, 0, 10'd128, 24'h800002, 2'b10, 5'h0, 36'h0_4000_0002);
    op(3, 0, 10'd128, 24'h800002, 2'b11, 5'h0, 36'h0_4000_0003);
    op(4, 0, 10'd128, 24'hFFFFFF, 2'b11, 5'h0, 36'h0_4080_0000);
    op(1, 1, 10'd254, 24'hFFFFFF, 2'b10, 5'h0, 36'h0_FF80_0000);
    op(1, 0, 10'd254, 24'hFFFFFF, 2'b01, 5'h0, 36'h0_7F7F_FFFF);
    op(1, 0, 10'd255, 24'h800000, 2'b00, 5'h0, 36'h0_7F80_0000);
    one(1, 5'h0, 36'h0_3F80_0000);
    rd(4'h0, 34'h0_0004_0014);
    one(1, 5'h02, 36'h0_7FC0_0000);
    op(5, 1, 10'd127, 24'h800000, 2'b00, 5'h04, 36'h0_FF80_0000);
    op(3, 1, 10'h3F0, 24'h800000, 2'b00, 5'h0, 36'h0_8000_0000);
    one(7, 5'h0, 36'h0_3F80_0000);
    rd(4'h0, 34'h0_0004_107C);
    // traps under the invalid, zero-divide, inexact and overflow enables, and the error trap
    wr(4'h0, 32'h0004_0800, 2'h0);
    one(8, 5'h0, 36'h1_0000_0000);
    one(1, 5'h0, 36'h0_3F80_0000);
    wr(4'h0, 32'h0004_0400, 2'h0);
    one(6, 5'h04, 36'h1_0000_0000);
    wr(4'h0, 32'h0004_0080, 2'h0);
    one(1, 5'h0, 36'h1_0000_0000);
    d = $random(seed);
    one(9, 5'h0, {4'h0, d}, d);
    wr(4'h0, 32'h0004_0200, 2'h0);
    one(2, 5'h0, 36'h1_0000_0000);
    wr(4'h0, 32'h0, 2'h0);
    one(1, 5'h01, 36'h1_0000_0000);
    rd(4'h0, 34'h0_0002_0000);
    rd(4'h4, 34'h0_0000_0002);
    one(1, 5'h10, 36'h2_0000_0000);
    one(1, 5'h18, 36'h4_0000_0000);
    // size toggle, bank swap, pair move
    one(11, 5'h0, 36'h0, 32'h0, 1'b1);
    one(10, 5'h0, 36'h0, 32'h0, 1'b1);
    d = $random(seed);
    one(9, 5'h0, {4'h8, d}, d);
    one(11, 5'h0, 36'h0, 32'h0, 1'b1);
    rd(4'h0, 34'h0_0022_0000);
    d = $random(seed);
    one(9, 5'h0, {4'h0, d}, d);
    // status load holds off further operations
    one(12, 5'h0, 36'h0, 32'h0005_5AA5, 1'b1);
    u_fpre_cpu_model.idle();
    #1;
    n = 0;
    while (!OP_READY) begin
      @(posedge REF_CLK);
      #1;
      n++;
    end
    check(36'(n), 36'(LOAD_CYC - 1));
    @(posedge REF_CLK);
    rd(4'h0, 34'h0_0005_5AA5);
    repeat (4) @(posedge REF_CLK);
    check(36'(u_fpre_cpu_model.q.size() + rq.size()), 36'h0);
    conclude();
  end
endmodule
`default_nettype wire
